//--- lbs_pkg.sv
// Package: register map, fields, reset values and timing for the LIN break/sync block
`default_nettype none
package lbs_pkg;
	// Register offsets (byte addresses)
	localparam logic [31:0] OFF_SYNC_PERIOD_COUNT   = 32'hffff0788;
	localparam logic [31:0] OFF_SYNC_EDGE_CONFIG    = 32'hffff078c;
	localparam logic [31:0] OFF_BREAK_TIMER_COMPARE = 32'hffff0790;
	localparam logic [31:0] OFF_SYNC_CONTROL        = 32'hffff0780;
	localparam logic [31:0] OFF_SYNC_STATUS         = 32'hffff0784;
	// Edge configuration fields
	localparam int          START_LSB               = 0;
	localparam int          STOP_LSB                = 4;
	localparam logic [7:0]  EDGE_CFG_RESET          = 8'h32;
	// Sync control fields
	localparam int          CTL_RESET_BIT           = 0;
	localparam int          CTL_ENABLE_BIT          = 2;
	localparam int          CTL_MODE_BIT            = 6;
	localparam int          CTL_POL_BIT             = 7;
	localparam logic [7:0]  CTL_RESET_VAL           = 8'h00;
	// Status fields
	localparam int          STA_BREAK_BIT           = 0;
	localparam int          STA_STOP_BIT            = 2;
	localparam int          STA_ERROR_BIT           = 4;
	localparam int          STA_RESET_DONE_BIT      = 5;
	// Break compare reset value
	localparam logic [11:0] BREAK_CMP_RESET         = 12'h047;
	// Timing
	localparam int          CLK_HZ                  = 50000000;
	localparam int          LPO_HZ                  = 131000;
	localparam int          SYNC_HZ                 = 5000000;
	localparam int          RESET_HOLD_NS           = 15000;
	localparam int          RESET_HOLD_CYC          = RESET_HOLD_NS / (1000000000 / CLK_HZ);
	localparam int          LPO_DIV                 = CLK_HZ / LPO_HZ;
	localparam int          SYNC_DIV                = CLK_HZ / SYNC_HZ;
	// Master side bit time in clocks (20 kbps)
	localparam int          MST_BAUD                = 20000;
	localparam int          MST_BIT_CYC             = CLK_HZ / MST_BAUD;
	localparam int          MST_BREAK_BITS          = 13;
endpackage : lbs_pkg
`default_nettype wire

//--- lbs_if.sv
// Interface: single-wire LIN bus between the master and the slave timing hardware
`timescale 1ns/10ps
`default_nettype none
interface lbs_if;
	logic mst_o;
	logic mst_oe_n;
	logic slv_o;
	logic slv_oe_n;
	logic bus;
	// Open-drain wire with pull-up
	assign bus = ((!mst_oe_n && !mst_o) || (!slv_oe_n && !slv_o)) ? 1'b0 : 1'b1;
	modport master (output mst_o, output mst_oe_n, input bus);
	modport slave  (output slv_o, output slv_oe_n, input bus);
endinterface : lbs_if
`default_nettype wire

//--- lbs_tick.sv
// Module: divider producing a one-cycle tick at a given ratio
`timescale 1ns/10ps
`default_nettype none
module lbs_tick #(
	parameter int DIV = 10
) (
	// Clock and reset
	input  wire logic i_clk,
	input  wire logic i_nrst,
	input  wire logic i_clr,
	// Tick
	output logic      o_tick
);
	logic [15:0] cnt_q;
	logic [15:0] cnt_d;

	always_comb begin
		if (i_clr || cnt_q == 16'(DIV - 1)) begin
			cnt_d = 16'h0000;
		end else begin
			cnt_d = cnt_q + 16'h0001;
		end
	end

	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			cnt_q <= 16'h0000;
		end else begin
			cnt_q <= cnt_d;
		end
	end

	assign o_tick = !i_clr && (cnt_q == 16'(DIV - 1));
endmodule : lbs_tick
`default_nettype wire

//--- lbs_slave.sv
// Module: slave LIN break and sync timing hardware with Avalon-MM registers
//
// Implementation choice: register access over Avalon-MM.
`timescale 1ns/10ps
`default_nettype none
module lbs_slave (
	// Clock and reset
	input  wire logic        i_clk,
	input  wire logic        i_nrst,
	// Avalon-MM slave
	input  wire logic [31:0] i_address,
	input  wire logic        i_read,
	input  wire logic        i_write,
	input  wire logic [3:0]  i_byteenable,
	input  wire logic [31:0] i_writedata,
	output logic [31:0]      o_readdata,
	output logic             o_waitrequest,
	output logic             o_break_irq,
	// LIN bus
	lbs_if.slave             lin
);
	typedef enum logic [1:0] {LBS_IDLE, LBS_ARMED, LBS_TIMING, LBS_DONE} lbs_sync_e;

	logic [7:0]  ctl_q, ctl_d;
	logic [7:0]  cfg_q, cfg_d;
	logic [11:0] cmp_q, cmp_d;
	logic [11:0] brk_q, brk_d;
	logic        brk_run_q, brk_run_d;
	logic [15:0] per_q, per_d;
	logic [3:0]  fall_q, fall_d;
	logic [3:0]  stop_q, stop_d;
	logic [5:0]  sta_q, sta_d;
	logic [9:0]  rst_cnt_q, rst_cnt_d;
	logic        bus_q, ack_q, ack_d;
	logic [31:0] rd_q, rd_d;
	lbs_sync_e   st_q, st_d;
	logic        lpo_tick, syn_tick, fall, rise, soft_rst, en, stop_edge, acc, rd_brk;

	lbs_tick #(.DIV(lbs_pkg::LPO_DIV)) u_lpo (.i_clk(i_clk), .i_nrst(i_nrst), .i_clr(1'b0), .o_tick(lpo_tick));
	lbs_tick #(.DIV(lbs_pkg::SYNC_DIV)) u_syn (.i_clk(i_clk), .i_nrst(i_nrst), .i_clr(soft_rst), .o_tick(syn_tick));

	assign lin.slv_o    = 1'b1;
	assign lin.slv_oe_n = 1'b1;
	assign soft_rst     = ctl_q[lbs_pkg::CTL_RESET_BIT];
	assign en           = ctl_q[lbs_pkg::CTL_ENABLE_BIT] && !soft_rst;
	assign fall         = bus_q && !lin.bus;
	assign rise         = !bus_q && lin.bus;
	assign stop_edge    = ctl_q[lbs_pkg::CTL_POL_BIT] ? rise : fall;
	assign acc          = (i_read || i_write) && !ack_q;
	assign rd_brk       = acc && i_read && i_address == lbs_pkg::OFF_BREAK_TIMER_COMPARE;
	assign o_waitrequest = (i_read || i_write) && !ack_q;
	assign o_readdata   = rd_q;
	assign o_break_irq  = sta_q[lbs_pkg::STA_BREAK_BIT] || sta_q[lbs_pkg::STA_ERROR_BIT];

	always_comb begin
		ctl_d     = ctl_q;
		cfg_d     = cfg_q;
		cmp_d     = cmp_q;
		brk_d     = brk_q;
		brk_run_d = brk_run_q;
		per_d     = per_q;
		fall_d    = fall_q;
		stop_d    = stop_q;
		sta_d     = sta_q;
		rst_cnt_d = rst_cnt_q;
		st_d      = st_q;
		ack_d     = acc;
		rd_d      = rd_q;
		// Register reads
		if (acc && i_read) begin
			case (i_address)
				lbs_pkg::OFF_SYNC_PERIOD_COUNT:   rd_d = {16'h0000, per_q};
				lbs_pkg::OFF_SYNC_EDGE_CONFIG:    rd_d = {24'h000000, cfg_q};
				lbs_pkg::OFF_BREAK_TIMER_COMPARE: rd_d = {20'h00000, brk_q};
				lbs_pkg::OFF_SYNC_CONTROL:        rd_d = {24'h000000, ctl_q};
				lbs_pkg::OFF_SYNC_STATUS:         rd_d = {26'h0000000, sta_q};
				default:                          rd_d = 32'h00000000;
			endcase
		end
		// Register writes land at the edge after the one that ends waitrequest; status is write-one-to-clear
		if (ack_q && i_write && i_byteenable[0]) begin
			case (i_address)
				lbs_pkg::OFF_SYNC_EDGE_CONFIG:    cfg_d = i_writedata[7:0];
				lbs_pkg::OFF_BREAK_TIMER_COMPARE: cmp_d = (i_byteenable[1]) ? i_writedata[11:0]
					: {cmp_q[11:8], i_writedata[7:0]};
				lbs_pkg::OFF_SYNC_CONTROL:        ctl_d = i_writedata[7:0];
				lbs_pkg::OFF_SYNC_STATUS:         sta_d = sta_q & ~i_writedata[5:0];
				default:                          ;
			endcase
		end
		// Break timer
		if (fall || rd_brk) begin
			brk_d     = 12'h000;
			brk_run_d = fall ? 1'b1 : brk_run_q;
		end else if (rise) begin
			brk_run_d = 1'b0;
		end else if (brk_run_q && lpo_tick) begin
			brk_d = brk_q + 12'h001;
			if (en && !ctl_q[lbs_pkg::CTL_MODE_BIT] && brk_q + 12'h001 == cmp_q) begin
				sta_d[lbs_pkg::STA_BREAK_BIT] = 1'b1;
				st_d     = LBS_ARMED;
				fall_d   = 4'h1;
				stop_d   = 4'h1;
				per_d    = 16'h0000;
			end
			if (en && brk_q == 12'hfff) begin
				sta_d[lbs_pkg::STA_ERROR_BIT] = 1'b1;
				brk_run_d = 1'b0;
			end
		end
		// Sync period timer
		case (st_q)
			LBS_ARMED: begin
				if (fall) begin
					fall_d = fall_q + 4'h1;
					if (fall_q + 4'h1 == cfg_q[lbs_pkg::START_LSB +: 4]) begin
						st_d = LBS_TIMING;
					end
				end
			end
			LBS_TIMING: begin
				if (syn_tick) begin
					per_d = per_q + 16'h0001;
				end
				if (stop_edge) begin
					stop_d = stop_q + 4'h1;
					if (stop_q + 4'h1 == cfg_q[lbs_pkg::STOP_LSB +: 4]) begin
						st_d = LBS_DONE;
						sta_d[lbs_pkg::STA_STOP_BIT] = 1'b1;
					end
				end
				if (fall) begin
					fall_d = fall_q + 4'h1;
				end
			end
			LBS_DONE: ;
			default: ;
		endcase
		if (ctl_q[lbs_pkg::CTL_POL_BIT] == 1'b0 && st_q == LBS_ARMED && fall) begin
			stop_d = fall_q + 4'h1;
		end
		if (!en) begin
			st_d = (st_q == LBS_DONE) ? LBS_DONE : LBS_IDLE;
		end
		// Self-clearing logic reset
		if (soft_rst) begin
			if (rst_cnt_q == 10'(lbs_pkg::RESET_HOLD_CYC - 1)) begin
				ctl_d[lbs_pkg::CTL_RESET_BIT] = 1'b0;
				sta_d[lbs_pkg::STA_RESET_DONE_BIT] = 1'b1;
				rst_cnt_d = 10'h000;
			end else begin
				rst_cnt_d = rst_cnt_q + 10'h001;
			end
			cfg_d     = lbs_pkg::EDGE_CFG_RESET;
			cmp_d     = lbs_pkg::BREAK_CMP_RESET;
			brk_d     = 12'h000;
			brk_run_d = 1'b0;
			per_d     = 16'h0000;
			sta_d[4:0] = 5'h00;
			st_d      = LBS_IDLE;
		end
	end

	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			ctl_q     <= lbs_pkg::CTL_RESET_VAL;
			cfg_q     <= lbs_pkg::EDGE_CFG_RESET;
			cmp_q     <= lbs_pkg::BREAK_CMP_RESET;
			brk_q     <= 12'h000;
			brk_run_q <= 1'b0;
			per_q     <= 16'h0000;
			fall_q    <= 4'h0;
			stop_q    <= 4'h0;
			sta_q     <= 6'h00;
			rst_cnt_q <= 10'h000;
			bus_q     <= 1'b1;
			ack_q     <= 1'b0;
			rd_q      <= 32'h00000000;
			st_q      <= LBS_IDLE;
		end else begin
			ctl_q     <= ctl_d;
			cfg_q     <= cfg_d;
			cmp_q     <= cmp_d;
			brk_q     <= brk_d;
			brk_run_q <= brk_run_d;
			per_q     <= per_d;
			fall_q    <= fall_d;
			stop_q    <= stop_d;
			sta_q     <= sta_d;
			rst_cnt_q <= rst_cnt_d;
			bus_q     <= lin.bus;
			ack_q     <= ack_d;
			rd_q      <= rd_d;
			st_q      <= st_d;
		end
	end
endmodule : lbs_slave
`default_nettype wire

//--- lbs_master.sv
// Module: LIN master end sending break, sync byte and one identifier byte
`timescale 1ns/10ps
`default_nettype none
module lbs_master (
	// Clock and reset
	input  wire logic       i_clk,
	input  wire logic       i_nrst,
	// Frame request
	input  wire logic       i_start,
	input  wire logic [7:0] i_ident,
	output logic            o_busy,
	// LIN bus
	lbs_if.master           lin
);
	typedef enum logic [1:0] {LBM_IDLE, LBM_BREAK, LBM_DELIM, LBM_BYTES} lbs_mst_e;

	lbs_mst_e    st_q, st_d;
	logic [15:0] cyc_q, cyc_d;
	logic [4:0]  bit_q, bit_d;
	logic [19:0] sh_q, sh_d;
	logic        tx_q, tx_d;
	logic        bit_end;

	assign bit_end      = cyc_q == 16'(lbs_pkg::MST_BIT_CYC - 1);
	assign lin.mst_o    = tx_q;
	assign lin.mst_oe_n = 1'b0;
	assign o_busy       = st_q != LBM_IDLE;

	always_comb begin
		st_d  = st_q;
		cyc_d = bit_end ? 16'h0000 : cyc_q + 16'h0001;
		bit_d = bit_q;
		sh_d  = sh_q;
		tx_d  = tx_q;
		case (st_q)
			LBM_IDLE: begin
				cyc_d = 16'h0000;
				tx_d  = 1'b1;
				if (i_start) begin
					st_d  = LBM_BREAK;
					bit_d = 5'h00;
					tx_d  = 1'b0;
					sh_d  = {1'b1, i_ident, 1'b0, 1'b1, 8'h55, 1'b0};
				end
			end
			LBM_BREAK: begin
				if (bit_end) begin
					bit_d = bit_q + 5'h01;
					if (bit_q == 5'(lbs_pkg::MST_BREAK_BITS - 1)) begin
						st_d = LBM_DELIM;
						tx_d = 1'b1;
					end
				end
			end
			LBM_DELIM: begin
				if (bit_end) begin
					st_d  = LBM_BYTES;
					bit_d = 5'h00;
					tx_d  = sh_q[0];
					sh_d  = {1'b1, sh_q[19:1]};
				end
			end
			LBM_BYTES: begin
				if (bit_end) begin
					bit_d = bit_q + 5'h01;
					tx_d  = sh_q[0];
					sh_d  = {1'b1, sh_q[19:1]};
					if (bit_q == 5'h13) begin
						st_d = LBM_IDLE;
						tx_d = 1'b1;
					end
				end
			end
			default: st_d = LBM_IDLE;
		endcase
	end

	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			st_q  <= LBM_IDLE;
			cyc_q <= 16'h0000;
			bit_q <= 5'h00;
			sh_q  <= 20'hfffff;
			tx_q  <= 1'b1;
		end else begin
			st_q  <= st_d;
			cyc_q <= cyc_d;
			bit_q <= bit_d;
			sh_q  <= sh_d;
			tx_q  <= tx_d;
		end
	end
endmodule : lbs_master
`default_nettype wire

//--- lbs_link_asserts.sv
// Checker: wire-level timing of the LIN header between the master and slave ends
`timescale 1ns/10ps
`default_nettype none
module lbs_link_asserts (
	// Clock and reset
	input  wire logic i_clk,
	input  wire logic i_nrst,
	// Bus signals
	input  wire logic mst_o,
	input  wire logic mst_oe_n,
	input  wire logic slv_o,
	input  wire logic slv_oe_n,
	input  wire logic bus
);
	localparam int BT  = lbs_pkg::MST_BIT_CYC;
	localparam int BRK = BT * lbs_pkg::MST_BREAK_BITS;
	int   lo_q;
	int   hi_q;
	int   nfall_q;
	logic bus_q;
	// Run lengths and falling-edge ordinal
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			lo_q    <= 0;
			hi_q    <= 0;
			nfall_q <= 0;
			bus_q   <= 1'b1;
		end else begin
			bus_q <= bus;
			lo_q  <= bus ? 0 : lo_q + 1;
			hi_q  <= bus ? hi_q + 1 : 0;
			if (bus_q && !bus) begin
				nfall_q <= nfall_q + 1;
			end
		end
	end
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_nrst);
	AST_SLV_LISTEN: assert property (slv_oe_n) else $error("slave end drives the bus");
	AST_MST_DRIVE: assert property (!mst_oe_n) else $error("master end released the bus");
	AST_NO_GLITCH: assert property ($fell(bus) |-> !bus[*8]) else $error("short low glitch");
	AST_BRK_LEN: assert property ($rose(bus) && nfall_q == 1 |-> lo_q >= BRK)
		else $error("break too short");
	AST_DELIM: assert property ($fell(bus) && nfall_q == 1 |-> hi_q == BT)
		else $error("delimiter length");
	AST_SYNC_LOW: assert property ($rose(bus) && nfall_q inside {[2:6]} |-> lo_q == BT)
		else $error("sync low bit length");
	AST_SYNC_HIGH: assert property ($fell(bus) && nfall_q inside {[2:5]} |-> hi_q == BT)
		else $error("sync high bit length");
	AST_RUN_MULT: assert property ($rose(bus) && nfall_q > 1 |-> lo_q % BT == 0)
		else $error("low run off grid");
	cover property ($rose(bus) && nfall_q == 1);
	cover property ($fell(bus) && nfall_q == 5);
	cover property ($fell(bus) && nfall_q == 6);
endmodule : lbs_link_asserts
`default_nettype wire

//--- tb.sv
// Testbench: one LIN header from master to slave, with register checks over Avalon-MM
`timescale 1ns/10ps
`default_nettype none
module tb;
	logic        i_clk;
	logic        i_nrst;
	logic [31:0] address;
	logic        rd;
	logic        wr;
	logic [31:0] wdata;
	logic [31:0] rdata;
	logic        waitreq;
	logic        irq;
	logic        start;
	logic [7:0]  ident;
	logic        busy;
	logic [31:0] q;
	int          err_total;
	int          tests_run;
	int          cfg_m;
	int          per_m;
	int          n;
	int          exp_q[$];
	lbs_if lin ();
	lbs_slave i_lbs_slave (.i_clk(i_clk), .i_nrst(i_nrst), .i_address(address), .i_read(rd), .i_write(wr),
		.i_byteenable(4'hf), .i_writedata(wdata), .o_readdata(rdata), .o_waitrequest(waitreq),
		.o_break_irq(irq), .lin(lin.slave));
	lbs_master i_lbs_master (.i_clk(i_clk), .i_nrst(i_nrst), .i_start(start), .i_ident(ident), .o_busy(busy),
		.lin(lin.master));
	lbs_link_asserts u_chk (.i_clk(i_clk), .i_nrst(i_nrst), .mst_o(lin.mst_o), .mst_oe_n(lin.mst_oe_n),
		.slv_o(lin.slv_o), .slv_oe_n(lin.slv_oe_n), .bus(lin.bus));
	initial begin
		i_clk = 1'b0;
		forever #10 i_clk = ~i_clk;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic chk_near(input logic [31:0] got, input int exp);
		tests_run++;
		if ((^got === 1'bx) || int'(got) < exp - 1 || int'(got) > exp + 1) begin
			err_total++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk_near
	task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
		int k;
		k = 0;
		@(posedge i_clk);
		address <= a;
		wdata <= d;
		rd <= !w;
		wr <= w;
		do begin
			@(posedge i_clk);
			k++;
		end while (waitreq !== 1'b0 && k < 50);
		r = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
		if (k >= 50) err_total++;
	endtask : xfer
	task automatic final_report();
		$display("tests_run=%0d err_total=%0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : final_report
	initial begin
		repeat (95000) @(posedge i_clk);
		err_total++;
		final_report();
	end
	initial begin
		address = '0;
		rd = 1'b0;
		wr = 1'b0;
		wdata = '0;
		start = 1'b0;
		ident = '0;
		i_nrst = 1'b0;
		err_total = 0;
		tests_run = 0;
		void'($urandom(79608));
		repeat (12) @(posedge i_clk);
		i_nrst <= 1'b1;
		cfg_m = 32'h32;
		xfer(0, lbs_pkg::OFF_SYNC_EDGE_CONFIG, '0, q);
		chk(q, cfg_m);
		xfer(0, lbs_pkg::OFF_SYNC_PERIOD_COUNT, '0, q);
		chk(q, 32'h0);
		xfer(0, 32'hffff07fc, '0, q);
		chk(q, 32'h0);
		$display("test reset values done");
		repeat (4) begin
			cfg_m = int'($urandom & 32'hff);
			exp_q.push_back(cfg_m);
			xfer(1, lbs_pkg::OFF_SYNC_EDGE_CONFIG, cfg_m, q);
			xfer(0, lbs_pkg::OFF_SYNC_EDGE_CONFIG, '0, q);
			chk(q, exp_q.pop_front());
		end
		cfg_m = 32'h62;
		xfer(1, lbs_pkg::OFF_SYNC_EDGE_CONFIG, cfg_m, q);
		$display("test edge config done");
		xfer(1, lbs_pkg::OFF_SYNC_CONTROL, 32'hc4, q);
		xfer(0, lbs_pkg::OFF_SYNC_CONTROL, '0, q);
		chk(q, 32'hc4);
		xfer(1, lbs_pkg::OFF_BREAK_TIMER_COMPARE, 32'h47 + ($urandom & 32'h7), q);
		xfer(0, lbs_pkg::OFF_BREAK_TIMER_COMPARE, '0, q);
		chk(q, 32'h0);
		$display("test control and compare done");
		xfer(1, lbs_pkg::OFF_SYNC_CONTROL, 32'h04, q);
		ident <= 8'($urandom);
		start <= 1'b1;
		@(posedge i_clk);
		start <= 1'b0;
		repeat (2) @(posedge i_clk);
		n = 0;
		while (busy !== 1'b0 && n < 90000) begin
			@(posedge i_clk);
			n++;
		end
		per_m = 8 * lbs_pkg::MST_BIT_CYC / lbs_pkg::SYNC_DIV;
		xfer(0, lbs_pkg::OFF_SYNC_STATUS, '0, q);
		chk(q & 32'h15, 32'h05);
		chk({31'h0, irq}, 32'h1);
		xfer(0, lbs_pkg::OFF_SYNC_PERIOD_COUNT, '0, q);
		chk_near(q, per_m);
		xfer(0, lbs_pkg::OFF_BREAK_TIMER_COMPARE, '0, q);
		xfer(0, lbs_pkg::OFF_BREAK_TIMER_COMPARE, '0, q);
		chk(q, 32'h0);
		$display("test frame done");
		xfer(1, lbs_pkg::OFF_SYNC_STATUS, 32'h15, q);
		xfer(0, lbs_pkg::OFF_SYNC_STATUS, '0, q);
		chk(q & 32'h15, 32'h0);
		chk({31'h0, irq}, 32'h0);
		xfer(0, lbs_pkg::OFF_SYNC_PERIOD_COUNT, '0, q);
		chk_near(q, per_m);
		$display("test status clear done");
		xfer(1, lbs_pkg::OFF_SYNC_CONTROL, 32'h01, q);
		n = 0;
		do begin
			xfer(0, lbs_pkg::OFF_SYNC_STATUS, '0, q);
			n++;
		end while (q[5] !== 1'b1 && n < 1000);
		chk(q & 32'h20, 32'h20);
		xfer(0, lbs_pkg::OFF_SYNC_CONTROL, '0, q);
		chk(q & 32'h01, 32'h0);
		xfer(0, lbs_pkg::OFF_SYNC_EDGE_CONFIG, '0, q);
		chk(q, 32'h32);
		xfer(0, lbs_pkg::OFF_SYNC_PERIOD_COUNT, '0, q);
		chk(q, 32'h0);
		$display("test logic reset done");
		final_report();
	end
endmodule : tb
`default_nettype wire
